// file: hw/pi_loop_feedback_loss.sv
// Purpose: PI process loop with feedback loss supervision, Avalon slave
// Assumes: setpoint, feedback, reference come from logic on clk_i
// Notes:   Loop and detector timers step once per control tick; flags clear on the next clock
//
// The Avalon-MM register port and the register offsets were chosen for this implementation.
`default_nettype none
// Behaviour
// - Mode 0 off, mode 1 output is reference
// - Mode 3 adds output to reference
// - Deviation times gain 0..25.00, default 2.00
// - Integral with time up to 360 s, zero off
// - Integral clamped to 0..100 % of maximum
// - Sum of P and I clamped to 0..100 % of maximum
// - Signed offset of +-100 % added to output
// - First-order filter 0..10 s, zero bypasses
// - Deviation positive when feedback below setpoint
// - Sense 0 direct, 1 inverts output sign
// - Output gain 0..25.00, default 1.00
// - No reverse: negative output clamps, drive stops
// - Reverse permitted: negative output runs reversed
// - Trim mode ignores reverse, no zero limit
// - Low flag after feedback low for time
// - High flag after feedback high beyond time
// - Flags and alarm clear on return in range
// - Actions 0 and 3 raise flags only
// - Actions 1 and 4 raise alarm, keep running
// - Action 2 latches fault, stops the motor
// - Actions 0..2 detect while loop pin-disabled
// - Actions 3 and 4 suspend while pin-disabled
// - Action 5 is fault with suspension
module pi_loop_feedback_loss
   import pi_loop_pkg::*;
#(
   parameter int TICK_CYCLES_P = TICK_CYCLES
) (
   // Clock and reset
   input  wire logic               clk_i,
   input  wire logic               rst_n_i,
   // Avalon-MM slave
   input  wire logic [7:0]         avs_address_i,
   input  wire logic               avs_read_i,
   input  wire logic               avs_write_i,
   input  wire logic [31:0]        avs_writedata_i,
   input  wire logic [3:0]         avs_byteenable_i,
   output logic      [31:0]        avs_readdata_o,
   output logic                    avs_waitrequest_o,
   // Process values
   input  wire logic [15:0]        setpoint_i,
   input  wire logic [15:0]        feedback_i,
   input  wire logic signed [15:0] freq_ref_i,
   input  wire logic               pi_disable_i,
   // Drive outputs
   output logic signed [31:0]      freq_out_o,
   output logic                    reverse_o,
   output logic                    drive_stop_o,
   output logic                    fb_low_o,
   output logic                    fb_high_o,
   output logic                    alarm_o,
   output logic                    fault_o
);
   // State
   cfg_t               cfg_reg;         // Software settings
   bus_state_t         bus_reg;         // Bus handshake phase
   logic [31:0]        rdata_reg;       // Captured read word
   logic [31:0]        tick_cnt_reg;    // Tick divider
   logic               dis_meta_reg;    // Disable pin, first stage
   logic               dis_sync_reg;    // Disable pin, synchronised
   wide_t              acc_reg;         // Integral accumulator
   wide_t              fy_reg;          // Filter state with fraction
   logic signed [31:0] pi_out_reg;      // Controller output
   logic signed [31:0] freq_out_reg;    // Resulting reference
   logic               reverse_reg;     // Reverse rotation command
   logic               stop_reg;        // Stop from clamped output
   logic               fault_reg;       // Latched loss fault
   logic [31:0]        cnt_reg [2];     // Detection timers
   logic               flag_reg [2];    // Low and high flags

   // Decode and handshake wires
   wire logic [5:0]  sel_w    = avs_address_i[7:2];
   wire logic        req_w    = avs_read_i | avs_write_i;
   wire logic        wr_take_w = avs_write_i && (bus_reg == BUS_ACK);
   wire logic        tick_w   = tick_cnt_reg == 32'(TICK_CYCLES_P - 1);
   wire logic        fault_clr_w;
   wire logic [31:0] wval_w;
   wire logic [31:0] cur_w;

   // Saturate an unsigned field to its maximum
   function automatic logic [15:0] sat_u(input logic [15:0] v,
                                         input logic [15:0] mx);
      return (v > mx) ? mx : v;
   endfunction

   // Saturate a signed percentage to +-100 %
   function automatic logic signed [15:0] sat_s(input logic signed [15:0] v);
      if (v > $signed(PCT_MAX)) begin
         return $signed(PCT_MAX);
      end
      return (v < PCT_NEG) ? PCT_NEG : v;
   endfunction

   // Symmetric clamp of a wide value
   function automatic wide_t wsat(input wide_t v, input wide_t lim);
      if (v > lim) begin
         return lim;
      end
      return (v < -lim) ? -lim : v;
   endfunction

   // Read multiplexer, also base for byte-lane merging
   function automatic logic [31:0] rd_sel(input logic [5:0] s);
      unique case (s)
         REG_CTRL: return {25'h0000000, cfg_reg.action, cfg_reg.reverse,
                           cfg_reg.sense, cfg_reg.mode};
         REG_KP:   return {16'h0000, cfg_reg.kp};
         REG_TI:   return {16'h0000, cfg_reg.ti};
         REG_ICL:  return {16'h0000, cfg_reg.iclamp};
         REG_OCL:  return {16'h0000, cfg_reg.oclamp};
         REG_OFS:  return {16'h0000, cfg_reg.offset};
         REG_FILT: return {16'h0000, cfg_reg.filt};
         REG_OGN:  return {16'h0000, cfg_reg.ogain};
         REG_LTH:  return {16'h0000, cfg_reg.low_thr};
         REG_LTM:  return {16'h0000, cfg_reg.low_time};
         REG_HTH:  return {16'h0000, cfg_reg.high_thr};
         REG_HTM:  return {16'h0000, cfg_reg.high_time};
         REG_STAT: return {26'h0000000, stop_reg, reverse_reg, fault_reg,
                           alarm_o, flag_reg[1], flag_reg[0]};
         REG_PIO:  return pi_out_reg;
         REG_FOUT: return freq_out_reg;
         default:  return 32'h0000_0000;
      endcase
   endfunction

   // Merge written byte lanes over the current word
   generate
      for (genvar b = 0; b < 4; b++) begin : g_lane
         assign wval_w[8*b+7:8*b] = avs_byteenable_i[b] ?
            avs_writedata_i[8*b+7:8*b] : cur_w[8*b+7:8*b];
      end
   endgenerate
   assign cur_w = rd_sel(sel_w);
   assign fault_clr_w = wr_take_w && (sel_w == REG_STAT) &&
                        avs_byteenable_i[0] && avs_writedata_i[ST_FAULT];

   // One wait state on every access
   assign avs_waitrequest_o = req_w && (bus_reg != BUS_ACK);
   assign avs_readdata_o    = rdata_reg;

   // Bus phase and read capture
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bus_reg   <= BUS_IDLE;
         rdata_reg <= 32'h0000_0000;
      end else begin
         bus_reg   <= (req_w && bus_reg == BUS_IDLE) ? BUS_ACK : BUS_IDLE;
         if (avs_read_i && bus_reg == BUS_IDLE) begin
            rdata_reg <= cur_w;
         end
      end
   end

   // Register writes with range saturation
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg_reg <= CFG_RESET;
      end else if (wr_take_w) begin
         unique case (sel_w)
            REG_CTRL: begin
               cfg_reg.mode    <= wval_w[1:0];
               cfg_reg.sense   <= wval_w[CTL_SENSE];
               cfg_reg.reverse <= wval_w[CTL_REV];
               cfg_reg.action  <= (wval_w[CTL_ACT+2:CTL_ACT] > ACT_MAX) ?
                                  ACT_MAX : wval_w[CTL_ACT+2:CTL_ACT];
            end
            REG_KP:   cfg_reg.kp        <= sat_u(wval_w[15:0], KP_MAX);
            REG_TI:   cfg_reg.ti        <= sat_u(wval_w[15:0], TI_MAX);
            REG_ICL:  cfg_reg.iclamp    <= sat_u(wval_w[15:0], PCT_MAX);
            REG_OCL:  cfg_reg.oclamp    <= sat_u(wval_w[15:0], PCT_MAX);
            REG_OFS:  cfg_reg.offset    <= sat_s(wval_w[15:0]);
            REG_FILT: cfg_reg.filt      <= sat_u(wval_w[15:0], FILT_MAX);
            REG_OGN:  cfg_reg.ogain     <= sat_u(wval_w[15:0], KP_MAX);
            REG_LTH:  cfg_reg.low_thr   <= sat_u(wval_w[15:0], PCT_MAX);
            REG_LTM:  cfg_reg.low_time  <= sat_u(wval_w[15:0], TIME_MAX);
            REG_HTH:  cfg_reg.high_thr  <= sat_u(wval_w[15:0], PCT_MAX);
            REG_HTM:  cfg_reg.high_time <= sat_u(wval_w[15:0], TIME_MAX);
            default:  cfg_reg <= cfg_reg;
         endcase
      end
   end

   // Tick divider and disable pin synchroniser
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tick_cnt_reg <= 32'h0000_0000;
         dis_meta_reg <= 1'b0;
         dis_sync_reg <= 1'b0;
      end else begin
         tick_cnt_reg <= tick_w ? 32'h0000_0000 : tick_cnt_reg + 32'h1;
         dis_meta_reg <= pi_disable_i;
         dis_sync_reg <= dis_meta_reg;
      end
   end

   // Loop arithmetic, in order of the output path
   wire logic  run_w   = (cfg_reg.mode == MODE_REF ||
                          cfg_reg.mode == MODE_TRIM) && !dis_sync_reg;
   wire wide_t err_w   = wide_t'($signed({1'b0, setpoint_i})) -
                         wide_t'($signed({1'b0, feedback_i}));
   wire wide_t p_w     = (err_w * wide_t'(cfg_reg.kp)) / GAIN_W;
   wire wide_t ti_ms_w = wide_t'(cfg_reg.ti) * TENTH_W;
   wire logic  i_on_w  = cfg_reg.ti != 16'h0000;
   wire wide_t ilim_w  = wide_t'(cfg_reg.iclamp) * ti_ms_w;
   wire wide_t acc_nx_w = wsat(acc_reg + err_w * TICK_MS_W, ilim_w);
   wire wide_t i_w     = i_on_w ? acc_reg / ti_ms_w : WIDE_ZERO;
   wire wide_t sum_w   = wsat(p_w + i_w, wide_t'(cfg_reg.oclamp));
   wire wide_t ofs_w   = sum_w + wide_t'(cfg_reg.offset);
   wire wide_t fx_w    = ofs_w <<< FILT_FRAC;
   wire wide_t tf_w    = (cfg_reg.filt == 16'h0000) ? WIDE_ONE :
                         wide_t'(cfg_reg.filt) * CENT_W;
   wire wide_t fy_nx_w = (cfg_reg.filt == 16'h0000) ? fx_w :
                         fy_reg + ((fx_w - fy_reg) * TICK_MS_W) / tf_w;
   wire wide_t filt_w  = fy_nx_w >>> FILT_FRAC;
   wire wide_t sense_w = cfg_reg.sense ? -filt_w : filt_w;
   wire wide_t gain_w  = (sense_w * wide_t'(cfg_reg.ogain)) / GAIN_W;
   wire logic  neg_w   = gain_w < WIDE_ZERO;
   wire logic  ref_md_w = run_w && cfg_reg.mode == MODE_REF;
   wire logic  clamp_w = ref_md_w && neg_w && !cfg_reg.reverse;
   wire wide_t ref_w   = wide_t'(freq_ref_i);
   wire wide_t fo_w    = (!run_w)       ? ref_w :
                         (cfg_reg.mode == MODE_TRIM) ? ref_w + gain_w :
                         clamp_w        ? WIDE_ZERO : gain_w;

   // Integrator, filter and output registers, once per tick
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         acc_reg      <= WIDE_ZERO;
         fy_reg       <= WIDE_ZERO;
         pi_out_reg   <= 32'sh0000_0000;
         freq_out_reg <= 32'sh0000_0000;
         reverse_reg  <= 1'b0;
         stop_reg     <= 1'b0;
      end else if (tick_w) begin
         // Integral held at zero while off or loop idle
         acc_reg      <= (run_w && i_on_w) ? acc_nx_w : WIDE_ZERO;
         fy_reg       <= fy_nx_w;
         pi_out_reg   <= gain_w[31:0];
         freq_out_reg <= fault_reg ? 32'sh0000_0000 : fo_w[31:0];
         reverse_reg  <= ref_md_w && neg_w && cfg_reg.reverse;
         stop_reg     <= clamp_w;
      end
   end

   // Feedback loss supervision
   wire logic        det_on_w = (cfg_reg.action <= ACT_FLT) ||
                                !dis_sync_reg;
   wire logic        cond_w [2];
   wire logic [31:0] lim_w  [2];
   wire logic        any_w    = flag_reg[0] | flag_reg[1];
   wire logic        alm_act_w = cfg_reg.action == ACT_ALM ||
                                 cfg_reg.action == ACT_ALM_S;
   wire logic        flt_act_w = cfg_reg.action == ACT_FLT ||
                                 cfg_reg.action == ACT_FLT_S;
   assign cond_w[0] = det_on_w && (feedback_i < cfg_reg.low_thr);
   assign cond_w[1] = det_on_w && (feedback_i > cfg_reg.high_thr);
   assign lim_w[0]  = 32'(cfg_reg.low_time) * TENTH_TICKS;
   assign lim_w[1]  = 32'(cfg_reg.high_time) * TENTH_TICKS;

   // Low detector uses at-least, high detector strictly longer
   generate
      for (genvar d = 0; d < 2; d++) begin : g_det
         wire logic [31:0] inc_w = (cnt_reg[d] == CNT_MAX) ? cnt_reg[d] :
                                   cnt_reg[d] + 32'h1;
         wire logic        hit_w = (d == 0) ? (inc_w >= lim_w[d]) :
                                   (inc_w > lim_w[d]);
         always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               cnt_reg[d]  <= 32'h0000_0000;
               flag_reg[d] <= 1'b0;
            end else if (!cond_w[d]) begin
               cnt_reg[d]  <= 32'h0000_0000;
               flag_reg[d] <= 1'b0;
            end else if (tick_w) begin
               cnt_reg[d]  <= inc_w;
               flag_reg[d] <= flag_reg[d] | hit_w;
            end
         end
      end
   endgenerate

   // Fault latch, a new loss event wins over the clear
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fault_reg <= 1'b0;
      end else begin
         fault_reg <= (flt_act_w && any_w) ||
                      (fault_reg && !fault_clr_w);
      end
   end

   // Output pins
   assign fb_low_o     = flag_reg[0];
   assign fb_high_o    = flag_reg[1];
   assign alarm_o      = alm_act_w && any_w;
   assign fault_o      = fault_reg;
   assign drive_stop_o = fault_reg | stop_reg;
   assign freq_out_o   = freq_out_reg;
   assign reverse_o    = reverse_reg;

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence acc_wait_s;
      avs_waitrequest_o ##1 !avs_waitrequest_o;
   endsequence

   // Bus answers after exactly one wait state
   bus_wait_a: assert property (
      (req_w && bus_reg == BUS_IDLE) |-> acc_wait_s)
      else $error("access not answered after one wait state");
   // Output path and mode selection, one cycle after a tick
   mode_off_a: assert property (
      (tick_w && !run_w && !fault_reg) |=>
      freq_out_o == 32'($past(freq_ref_i)))
      else $error("disabled loop does not pass reference");
   trim_sum_a: assert property (
      (tick_w && run_w && cfg_reg.mode == MODE_TRIM && !fault_reg) |=>
      freq_out_o == 32'($past(freq_ref_i)) + pi_out_reg)
      else $error("trim mode does not add output to reference");
   no_rev_a: assert property (
      (tick_w && clamp_w && !fault_reg) |=>
      freq_out_o == 32'sh0000_0000 && drive_stop_o && !reverse_o)
      else $error("negative output not clamped with stop");
   rev_run_a: assert property (
      (tick_w && ref_md_w && neg_w && cfg_reg.reverse && !fault_reg) |=>
      reverse_o && freq_out_o == pi_out_reg && pi_out_reg < 0)
      else $error("reverse permitted output not passed");
   // Detector timing; a flag lags its condition by one edge
   low_time_a: assert property (
      fb_low_o |-> $past(cond_w[0]) && cnt_reg[0] >= lim_w[0])
      else $error("low flag before detection time");
   high_time_a: assert property (
      fb_high_o |-> $past(cond_w[1]) && cnt_reg[1] > lim_w[1])
      else $error("high flag before detection time");
   flag_clear_a: assert property (
      !cond_w[0] && !cond_w[1] |=> !fb_low_o && !fb_high_o && !alarm_o)
      else $error("flags stay after return in range");
   // Loss actions; alarm follows the action at once, fault an edge later
   flag_only_a: assert property (
      (cfg_reg.action == ACT_OUT && !fault_reg) |->
      !alarm_o ##1 !fault_o)
      else $error("flag-only action raised alarm or fault");
   fault_stop_a: assert property (
      (flt_act_w && any_w) |=> fault_o && drive_stop_o)
      else $error("loss fault not latched with stop");
   suspend_a: assert property (
      (cfg_reg.action > ACT_FLT && dis_sync_reg) [*2] |->
      !fb_low_o && !fb_high_o)
      else $error("detection not suspended while disabled");
   // Integral path: off with zero time, else held inside its clamp
   int_off_a: assert property (
      (tick_w && !i_on_w) |=> acc_reg == WIDE_ZERO)
      else $error("integral not off with zero time");
   int_clamp_a: assert property (
      (tick_w && run_w && i_on_w) |=>
      acc_reg <= $past(ilim_w) && acc_reg >= -$past(ilim_w))
      else $error("integral beyond its clamp");
   // Filter moves up toward a higher input and never past it
   filt_step_a: assert property (
      (tick_w && cfg_reg.filt != 16'h0000 && fx_w >= fy_reg) |=>
      fy_reg >= $past(fy_reg) && fy_reg <= $past(fx_w))
      else $error("filter stepped past its input");
endmodule
`default_nettype wire

// file: hw/pi_loop_pkg.sv
// Purpose: Shared constants, register map and types of the PI loop block
// Assumes: 100 MHz clock, values in 0.01 % steps of maximum frequency
// Notes:   Register indices are word indices; byte address is four times
`default_nettype none
package pi_loop_pkg;
   // Clock, tick and scaling
   localparam int CLK_FREQ_HZ  = 100_000_000;
   localparam int TICK_TIME_US = 1000;
   localparam int TICK_CYCLES  = TICK_TIME_US * (CLK_FREQ_HZ / 1_000_000);
   localparam int TICK_MS      = TICK_TIME_US / 1000;
   localparam int TENTH_S_MS   = 100;
   localparam int CENT_S_MS    = 10;
   localparam int GAIN_ONE     = 100;
   localparam int FILT_FRAC    = 8;
   localparam int WIDE_W       = 48;
   typedef logic signed [WIDE_W-1:0] wide_t;
   localparam wide_t TICK_MS_W  = wide_t'(TICK_MS);
   localparam wide_t TENTH_W    = wide_t'(TENTH_S_MS);
   localparam wide_t CENT_W     = wide_t'(CENT_S_MS);
   localparam wide_t GAIN_W     = wide_t'(GAIN_ONE);
   localparam wide_t WIDE_ZERO  = wide_t'(0);
   localparam wide_t WIDE_ONE   = wide_t'(1);
   localparam logic [31:0] TENTH_TICKS = 32'(TENTH_S_MS / TICK_MS);
   localparam logic [31:0] CNT_MAX     = 32'hFFFF_FFFF;
   // Loop modes and loss actions
   localparam logic [1:0] MODE_OFF  = 2'h0;
   localparam logic [1:0] MODE_REF  = 2'h1;
   localparam logic [1:0] MODE_TRIM = 2'h3;
   localparam logic [2:0] ACT_OUT   = 3'h0;
   localparam logic [2:0] ACT_ALM   = 3'h1;
   localparam logic [2:0] ACT_FLT   = 3'h2;
   localparam logic [2:0] ACT_ALM_S = 3'h4;
   localparam logic [2:0] ACT_FLT_S = 3'h5;
   // Register word indices
   localparam logic [5:0] REG_CTRL = 6'h00;
   localparam logic [5:0] REG_KP   = 6'h01;
   localparam logic [5:0] REG_TI   = 6'h02;
   localparam logic [5:0] REG_ICL  = 6'h03;
   localparam logic [5:0] REG_OCL  = 6'h04;
   localparam logic [5:0] REG_OFS  = 6'h05;
   localparam logic [5:0] REG_FILT = 6'h06;
   localparam logic [5:0] REG_OGN  = 6'h07;
   localparam logic [5:0] REG_LTH  = 6'h08;
   localparam logic [5:0] REG_LTM  = 6'h09;
   localparam logic [5:0] REG_HTH  = 6'h0A;
   localparam logic [5:0] REG_HTM  = 6'h0B;
   localparam logic [5:0] REG_STAT = 6'h0C;
   localparam logic [5:0] REG_PIO  = 6'h0D;
   localparam logic [5:0] REG_FOUT = 6'h0E;
   // Control and status field positions
   localparam int CTL_SENSE = 2;
   localparam int CTL_REV   = 3;
   localparam int CTL_ACT   = 4;
   localparam int ST_FAULT  = 3;
   // Limits of writable fields
   localparam logic [15:0] KP_MAX     = 16'h09C4;
   localparam logic [15:0] TI_MAX     = 16'h0E10;
   localparam logic [15:0] PCT_MAX    = 16'h2710;
   localparam logic signed [15:0] PCT_NEG = 16'shD8F0;
   localparam logic [15:0] FILT_MAX   = 16'h03E8;
   localparam logic [15:0] TIME_MAX   = 16'h00FF;
   localparam logic [2:0]  ACT_MAX    = 3'h5;
   // Configuration carrier
   typedef struct packed {
      logic [1:0]         mode;
      logic               sense;
      logic               reverse;
      logic [2:0]         action;
      logic [15:0]        kp;
      logic [15:0]        ti;
      logic [15:0]        iclamp;
      logic [15:0]        oclamp;
      logic signed [15:0] offset;
      logic [15:0]        filt;
      logic [15:0]        ogain;
      logic [15:0]        low_thr;
      logic [15:0]        low_time;
      logic [15:0]        high_thr;
      logic [15:0]        high_time;
   } cfg_t;
   localparam cfg_t CFG_RESET = '{mode: MODE_OFF, sense: 1'b0,
      reverse: 1'b0, action: ACT_OUT, kp: 16'h00C8, ti: 16'h0005,
      iclamp: 16'h2710, oclamp: 16'h2710, offset: 16'sh0000,
      filt: 16'h0000, ogain: 16'h0064, low_thr: 16'h0000,
      low_time: 16'h000A, high_thr: 16'h2710, high_time: 16'h000A};
   // Bus handshake states
   typedef enum logic [1:0] {BUS_IDLE = 2'b00, BUS_ACK = 2'b01} bus_state_t;
endpackage
`default_nettype wire

// file: test/pi_loop_feedback_loss_test.sv
// Purpose: Self-checking bench of the PI loop block
// Assumes: tick cut to 10 cycles, times still counted in ticks
// Notes:   Expected loop outputs come from bench function want, other expectations are constants or inline
`default_nettype none
module pi_loop_feedback_loss_test
   import pi_loop_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // Bench drive, bus capture and observed outputs
   logic               clk_i = 1'b0, rst_n = 1'b0, rd_en = 1'b0;
   logic               wr_en = 1'b0, dis = 1'b0, wt, neg_e;
   logic [7:0]         adr = 8'h00;
   logic [3:0]         be = 4'hF;
   logic [31:0]        wdat = 32'h0000_0000, rdat, rbuf;
   logic [15:0]        sp = 16'h0000, lvl = 16'h0000, fb;
   logic signed [15:0] rcmd = 16'sh0000, fref;
   logic signed [31:0] fout;
   logic               rev_w, stop_w, low_w, high_w, alm_w, flt_w;
   int                 err_count = 0, check_count = 0;
   // Free-running 100 MHz clock
   always #5 clk_i = ~clk_i;
   process_side_model u_side (.clk_i(clk_i), .level_i(lvl),
      .ref_i(rcmd), .feedback_o(fb), .freq_ref_o(fref));
   pi_loop_feedback_loss #(.TICK_CYCLES_P(10)) u_dut (.clk_i(clk_i),
      .rst_n_i(rst_n), .avs_address_i(adr), .avs_read_i(rd_en),
      .avs_write_i(wr_en), .avs_writedata_i(wdat),
      .avs_byteenable_i(be), .avs_readdata_o(rdat),
      .avs_waitrequest_o(wt), .setpoint_i(sp), .feedback_i(fb),
      .freq_ref_i(fref), .pi_disable_i(dis), .freq_out_o(fout),
      .reverse_o(rev_w), .drive_stop_o(stop_w), .fb_low_o(low_w),
      .fb_high_o(high_w), .alarm_o(alm_w), .fault_o(flt_w));
   // Counts, verdict and end of run
   task automatic wrap_up;
      $display("Mismatches %0d, checks %0d", err_count, check_count);
      if (err_count == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One access, held until waitrequest is sampled low
   task automatic bus(input logic w, logic [5:0] ix, logic [31:0] d);
      int n = 0;
      adr   <= {ix, 2'b00};
      wr_en <= w;
      rd_en <= !w;
      wdat  <= d;
      do @(posedge clk_i);
      while (wt !== 1'b0 && ++n < 50);
      rbuf = rdat;
      if (wt !== 1'b0) begin
         err_count++;
         wrap_up();
      end
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      @(posedge clk_i);
   endtask
   // Expected output; sign before the zero clamp kept in neg_e
   function automatic int want(input int md, sn, rv, e, kp, c, o, g, r);
      int p;
      p = e * kp / 100;
      p = (p > c) ? c : ((p < -c) ? -c : p);
      p = (p + o) * (sn ? -1 : 1) * g / 100;
      neg_e = (p < 0);
      return (md == 3) ? r + p : (md != 1) ? r : (neg_e && !rv) ? 0 : p;
   endfunction
   // Main sequence
   initial begin
      int md, rv, kp, ocl, ofs, og, f, rf, en;
      void'($urandom(49421));
      repeat (2) @(posedge clk_i);
      rst_n <= 1'b1;
      @(posedge clk_i);
      bus(1, REG_KP, 32'h0000_FFFF);
      bus(0, REG_KP, 0);
      chk(rbuf, {16'h0000, KP_MAX});
      bus(0, 6'h3F, 0);
      chk(rbuf, 32'h0000_0000);
      bus(1, REG_TI, 0);
      sp <= 16'h1388;
      // Random settings, largest gain first
      for (int i = 0; i < 16; i++) begin
         md = (i + 1) % 4;
         rv = i / 8 % 2;
         kp = (i == 0) ? 2500 : $urandom_range(0, 2500);
         ocl = $urandom_range(0, 10000);
         ofs = $urandom_range(0, 20000) - 10000;
         og = $urandom_range(0, 2500);
         f = $urandom_range(0, 10000);
         rf = $urandom_range(0, 20000) - 10000;
         bus(1, REG_CTRL, 32'(md + (i & 12)));
         bus(1, REG_KP, 32'(kp));
         bus(1, REG_OCL, 32'(ocl));
         bus(1, REG_OFS, 32'(ofs));
         bus(1, REG_OGN, 32'(og));
         lvl <= 16'(f);
         rcmd <= 16'(rf);
         repeat (25) @(posedge clk_i);
         chk(fout, 32'(want(md, i / 4 % 2, rv, 5000 - f, kp, ocl, ofs, og,
             rf)));
         chk(rev_w, md == 1 && neg_e && rv);
         chk(stop_w, md == 1 && neg_e && !rv);
      end
      // Every loss action, pin disabling first, then free
      bus(1, REG_LTH, 32'h0000_07D0);
      bus(1, REG_LTM, 0);
      bus(1, REG_HTM, 0);
      be <= 4'h1;
      for (int k = 0; k < 12; k++) begin
         en = (k >= 6 || k % 6 < 3);
         bus(1, REG_CTRL, 32'((k % 6) * 16));
         dis <= (k < 6);
         lvl <= (k % 2) ? 16'h2EE0 : 16'h03E8;
         repeat (25) @(posedge clk_i);
         chk({flt_w, alm_w, high_w, low_w},
             {en && k % 3 == 2, en && k % 3 == 1, en && k % 2, en && !(k % 2)});
         lvl <= 16'h1388;
         repeat (25) @(posedge clk_i);
         chk({alm_w, high_w, low_w}, 3'b000);
         bus(1, REG_STAT, 32'h0000_0008);
         chk(flt_w, 1'b0);
      end
      // Low timer must run its full time
      bus(1, REG_LTM, 1);
      lvl <= 16'h03E8;
      repeat (950) @(posedge clk_i);
      chk(low_w, 1'b0);
      repeat (100) @(posedge clk_i);
      chk(low_w, 1'b1);
      // Slow filter holding the output back, then the integral clamp
      be <= 4'hF;
      bus(1, REG_CTRL, 32'h0000_0001);
      bus(1, REG_STAT, 32'h0000_0008);
      bus(1, REG_KP, 0);
      bus(1, REG_OFS, 0);
      bus(1, REG_OCL, 32'h0000_2710);
      bus(1, REG_OGN, 32'h0000_0064);
      bus(1, REG_ICL, 32'h0000_01F4);
      bus(1, REG_TI, 1);
      bus(1, REG_FILT, 32'h0000_03E8);
      repeat (200) @(posedge clk_i);
      chk(fout < 32'sh0000_0064, 1'b1);
      bus(1, REG_FILT, 0);
      repeat (25) @(posedge clk_i);
      chk(fout, 32'h0000_01F4);
      wrap_up();
   end
endmodule
`default_nettype wire

// file: test/process_side_model.sv
// Purpose: Sensor and reference path facing the loop block
// Assumes: bench sets levels between control ticks
// Notes:   Registered, so values move one cycle after a command
`default_nettype none
module process_side_model (
   // Clock, bench commands and values toward the block
   input  wire logic               clk_i,
   input  wire logic [15:0]        level_i,
   input  wire logic signed [15:0] ref_i,
   output logic      [15:0]        feedback_o = 16'h0000,
   output logic signed [15:0]      freq_ref_o = 16'sh0000
);
   timeunit 1ns;
   timeprecision 1ns;
   // Sensor sample and reference update on the block clock
   always @(posedge clk_i) begin
      feedback_o <= level_i;
      freq_ref_o <= ref_i;
   end
endmodule
`default_nettype wire
